// ### ssp_pkg.sv
package ssp_pkg;
    // Bus addresses
    localparam logic [6:0] DEV_ADDR_STD = 7'h4C;
    localparam logic [6:0] DEV_ADDR_ALT = 7'h4D;
    localparam logic [6:0] ALERT_RESP_ADDR = 7'h0C;

    // Read pointer addresses
    localparam logic [7:0] RD_LOCAL_TEMP = 8'h00;
    localparam logic [7:0] RD_REMOTE_HI = 8'h01;
    localparam logic [7:0] RD_STATUS = 8'h02;
    localparam logic [7:0] RD_CONFIG = 8'h03;
    localparam logic [7:0] RD_CONV_RATE = 8'h04;
    localparam logic [7:0] RD_LOCAL_HIGH = 8'h05;
    localparam logic [7:0] RD_LOCAL_LOW = 8'h06;
    localparam logic [7:0] RD_REMOTE_HIGH = 8'h07;
    localparam logic [7:0] RD_REMOTE_LOW = 8'h08;
    localparam logic [7:0] RD_REMOTE_LO = 8'h10;
    localparam logic [7:0] RD_DEVICE_ID = 8'h3D;
    localparam logic [7:0] RD_MAKER_ID = 8'hFE;
    localparam logic [7:0] RD_REVISION = 8'hFF;

    // Write pointer addresses
    localparam logic [7:0] WR_CONFIG = 8'h09;
    localparam logic [7:0] WR_CONV_RATE = 8'h0A;
    localparam logic [7:0] WR_LOCAL_HIGH = 8'h0B;
    localparam logic [7:0] WR_LOCAL_LOW = 8'h0C;
    localparam logic [7:0] WR_REMOTE_HIGH = 8'h0D;
    localparam logic [7:0] WR_REMOTE_LOW = 8'h0E;
    localparam logic [7:0] SINGLE_CONVERSION_TRIGGER = 8'h0F;

    // Shared read/write addresses
    localparam logic [7:0] RW_OFFSET_HI = 8'h11;
    localparam logic [7:0] RW_OFFSET_LO = 8'h12;
    localparam logic [7:0] RW_REMOTE_HIGH_LO = 8'h13;
    localparam logic [7:0] RW_REMOTE_LOW_LO = 8'h14;
    localparam logic [7:0] RW_REMOTE_FS_LIMIT = 8'h19;
    localparam logic [7:0] RW_LOCAL_FS_LIMIT = 8'h20;
    localparam logic [7:0] RW_HYSTERESIS = 8'h21;
    localparam logic [7:0] RW_CONSEC_ALARM = 8'h22;

    // Values after reset
    localparam logic [7:0] CONFIG_RST = 8'h08;
    localparam logic [7:0] CONV_RATE_RST = 8'h06;
    localparam logic [7:0] HIGH_LIMIT_RST = 8'h55;
    localparam logic [7:0] LOW_LIMIT_RST = 8'h00;
    localparam logic [7:0] FS_LIMIT_RST = 8'h55;
    localparam logic [7:0] HYSTERESIS_RST = 8'h0A;
    localparam logic [7:0] CONSEC_RST = 8'h01;
    localparam logic [7:0] ZERO_RST = 8'h00;
    // Identity values are arbitrary
    localparam logic [7:0] DEVICE_ID_VAL = 8'h5A;
    localparam logic [7:0] MAKER_ID_VAL = 8'hA5;
    localparam logic [7:0] REVISION_VAL = 8'h01;

    // Field positions
    localparam int CFG_MASK_BIT = 7;
    localparam int CFG_STANDBY_BIT = 6;
    localparam int CFG_PIN_FS_BIT = 5;
    localparam int CONSEC_TO_BIT_A = 6;
    localparam int CONSEC_TO_BIT_B = 7;

    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int BUS_TIMEOUT_NS = 25000000;
    localparam int BUS_TIMEOUT_CYC = BUS_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int CONV_PERIOD_NS = 62500000;
    localparam int CONV_PERIOD_CYC = CONV_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef enum logic [2:0] {
        SSP_IDLE,
        SSP_ADDR,
        SSP_ACK_ADDR,
        SSP_WR_BYTE,
        SSP_ACK_WR,
        SSP_RD_BYTE,
        SSP_RD_ACK
    } ssp_state_t;
endpackage : ssp_pkg

// ### ssp_pin_sync.sv
`timescale 1ns/1ps
module ssp_pin_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pin,
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta;
    logic stable;
    logic prev;

    // Two stages before use; the third only feeds edge detection
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta <= 1'b1;
            stable <= 1'b1;
            prev <= 1'b1;
        end else begin
            meta <= pin;
            stable <= meta;
            prev <= stable;
        end
    end

    assign level = stable;
    assign rise = stable & ~prev;
    assign fall = ~stable & prev;
endmodule : ssp_pin_sync

// ### ssp_slave_port.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Standard variant answers bus address 0x4C after a start, and 0x0C only while its alarm is active.
// - Alternate variant answers bus address 0x4D instead.
// - A start is data falling while clock stays high.
// - After start, eight bits shift in: address MSB first, then direction.
// - On address match, pull data low for the ninth clock; otherwise idle.
// - Direction 0 is master write, direction 1 is master read.
// - Each byte is eight data clocks plus one acknowledge clock.
// - Data moves only while clock low; rising data at clock high is stop.
// - Direction is fixed at start; only a new start changes it.
// - Writes carry one or two bytes; reads return exactly one byte.
// - First written byte always loads the register pointer.
// - Second written byte goes to the register the pointer selects.
// - A read returns the register selected by the current pointer.
// - Write-only pointer addresses read back as zero.
// - In alarm mode the pin goes low on limit violation or open sensor.
// - While alarm low, answer alert response read with own address plus 1.
// - Lose arbitration on alert response when another device drives lower.
// - After answering alert response, release alarm only if cause is gone.
// - Configuration bit 6 enters standby and aborts a running conversion.
// - Write to 0x0F in standby runs one conversion; data is discarded.
// - Limits written in standby are compared with stored values at once.
// - Open comparator sampled at conversion start sets status bit 2.
// - Status flags latch until status read; fail-safe mode latches only bit 2.
// - Consecutive register bits 6 and 7 enable a 25 ms bus timeout.
// - Pointer content is not guaranteed after power-up.
module ssp_slave_port #(
    parameter bit ALT_VARIANT = 1'b0,
    parameter int TIMEOUT_CYC = ssp_pkg::BUS_TIMEOUT_CYC,
    parameter int CONV_CYC = ssp_pkg::CONV_PERIOD_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic serial_data_line_in,
    output logic serial_data_line_out,
    output logic serial_data_line_oe,
    input wire logic alarm_pin_in,
    output logic alarm_pin_out,
    output logic alarm_pin_oe,
    input wire logic open_sensor_in,
    input wire logic meas_done,
    input wire logic [7:0] meas_local,
    input wire logic [7:0] meas_remote_hi,
    input wire logic [7:0] meas_remote_lo,
    output logic conv_start,
    output logic conv_abort,
    output logic conv_busy,
    output logic standby
);
    import ssp_pkg::*;

    function automatic logic above(input logic [7:0] t, input logic [7:0] l);
        above = t > l;
    endfunction : above

    logic scl_s, scl_rise, scl_fall;
    logic sda_s, sda_rise, sda_fall;
    logic open_s, open_rise_unused, open_fall_unused;
    logic start_det, stop_det;
    ssp_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic rw;
    logic [1:0] byte_no;
    logic is_ara;
    logic wr_ptr, wr_reg, stat_clr, ara_done;
    logic [7:0] ptr;
    logic [7:0] rd_data, tx_byte;
    logic [6:0] own_addr;
    logic [7:0] cfg, rate, lhi, llo, rhi, rlo, ofs_hi, ofs_lo;
    logic [7:0] rhi_lo, rlo_lo, rfs_lim, lfs_lim, hyst, consec;
    logic [7:0] local_t, remote_hi, remote_lo;
    logic [6:2] flags;
    logic alarm_active;
    logic c_lhi, c_llo, c_rhi, c_rlo, c_rfs, c_lfs;
    logic fs_mode;
    logic [31:0] to_cnt;
    logic to_hit;
    logic [31:0] conv_timer;
    logic oneshot_pend, oneshot_run;
    logic start_now, abort_now, take_result;

    ssp_pin_sync u_scl (
        .clk(clk), .rst_n(rst_n), .pin(scl_in),
        .level(scl_s), .rise(scl_rise), .fall(scl_fall)
    );
    ssp_pin_sync u_sda (
        .clk(clk), .rst_n(rst_n), .pin(serial_data_line_in),
        .level(sda_s), .rise(sda_rise), .fall(sda_fall)
    );
    ssp_pin_sync u_open (
        .clk(clk), .rst_n(rst_n), .pin(open_sensor_in),
        .level(open_s), .rise(open_rise_unused), .fall(open_fall_unused)
    );

    assign own_addr = ALT_VARIANT ? DEV_ADDR_ALT : DEV_ADDR_STD;
    assign start_det = scl_s & sda_fall;
    assign stop_det = scl_s & sda_rise;
    assign fs_mode = cfg[CFG_PIN_FS_BIT];

    // Read decode; write-only and unmapped addresses give zero
    always_comb begin
        case (ptr)
            RD_LOCAL_TEMP: rd_data = local_t;
            RD_REMOTE_HI: rd_data = remote_hi;
            RD_STATUS: rd_data = {conv_busy, flags, c_rfs, c_lfs};
            RD_CONFIG: rd_data = cfg;
            RD_CONV_RATE: rd_data = rate;
            RD_LOCAL_HIGH: rd_data = lhi;
            RD_LOCAL_LOW: rd_data = llo;
            RD_REMOTE_HIGH: rd_data = rhi;
            RD_REMOTE_LOW: rd_data = rlo;
            RD_REMOTE_LO: rd_data = remote_lo;
            RW_OFFSET_HI: rd_data = ofs_hi;
            RW_OFFSET_LO: rd_data = ofs_lo;
            RW_REMOTE_HIGH_LO: rd_data = rhi_lo;
            RW_REMOTE_LOW_LO: rd_data = rlo_lo;
            RW_REMOTE_FS_LIMIT: rd_data = rfs_lim;
            RW_LOCAL_FS_LIMIT: rd_data = lfs_lim;
            RW_HYSTERESIS: rd_data = hyst;
            RW_CONSEC_ALARM: rd_data = consec;
            RD_DEVICE_ID: rd_data = DEVICE_ID_VAL;
            RD_MAKER_ID: rd_data = MAKER_ID_VAL;
            RD_REVISION: rd_data = REVISION_VAL;
            default: rd_data = ZERO_RST;
        endcase
    end

    assign tx_byte = is_ara ? {own_addr, 1'b1} : rd_data;

    // Serial protocol engine
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= SSP_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            rw <= 1'b0;
            byte_no <= 2'h0;
            is_ara <= 1'b0;
            serial_data_line_oe <= 1'b0;
            wr_ptr <= 1'b0;
            wr_reg <= 1'b0;
            stat_clr <= 1'b0;
            ara_done <= 1'b0;
        end else begin
            wr_ptr <= 1'b0;
            wr_reg <= 1'b0;
            stat_clr <= 1'b0;
            ara_done <= 1'b0;
            if (start_det) begin
                // A repeated start also lands here, so direction restarts
                state <= SSP_ADDR;
                bit_cnt <= 4'h0;
                serial_data_line_oe <= 1'b0;
            end else if (stop_det || to_hit) begin
                state <= SSP_IDLE;
                serial_data_line_oe <= 1'b0;
            end else begin
                case (state)
                    SSP_ADDR: begin
                        if (scl_rise) begin
                            shreg <= {shreg[6:0], sda_s};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && bit_cnt == BITS_PER_BYTE) begin
                            rw <= shreg[0];
                            if (shreg[7:1] == own_addr) begin
                                serial_data_line_oe <= 1'b1;
                                is_ara <= 1'b0;
                                state <= SSP_ACK_ADDR;
                            end else if (shreg[7:1] == ALERT_RESP_ADDR
                                         && shreg[0] && alarm_active) begin
                                serial_data_line_oe <= 1'b1;
                                is_ara <= 1'b1;
                                state <= SSP_ACK_ADDR;
                            end else begin
                                state <= SSP_IDLE;
                            end
                        end
                    end
                    SSP_ACK_ADDR: begin
                        if (scl_fall) begin
                            bit_cnt <= 4'h0;
                            byte_no <= 2'h0;
                            if (!rw) begin
                                serial_data_line_oe <= 1'b0;
                                state <= SSP_WR_BYTE;
                            end else begin
                                shreg <= tx_byte;
                                serial_data_line_oe <= ~tx_byte[7];
                                stat_clr <= ~is_ara && ptr == RD_STATUS;
                                state <= SSP_RD_BYTE;
                            end
                        end
                    end
                    SSP_WR_BYTE: begin
                        if (scl_rise) begin
                            shreg <= {shreg[6:0], sda_s};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && bit_cnt == BITS_PER_BYTE) begin
                            // Bytes past the second get no acknowledge
                            wr_ptr <= byte_no == 2'h0;
                            wr_reg <= byte_no == 2'h1;
                            serial_data_line_oe <= byte_no != 2'h2;
                            if (byte_no != 2'h2) begin
                                byte_no <= byte_no + 2'h1;
                            end
                            state <= SSP_ACK_WR;
                        end
                    end
                    SSP_ACK_WR: begin
                        if (scl_fall) begin
                            serial_data_line_oe <= 1'b0;
                            bit_cnt <= 4'h0;
                            state <= SSP_WR_BYTE;
                        end
                    end
                    SSP_RD_BYTE: begin
                        if (scl_rise) begin
                            bit_cnt <= bit_cnt + 4'h1;
                            // Released high but seen low: a lower address won
                            if (is_ara && !serial_data_line_oe && !sda_s) begin
                                state <= SSP_IDLE;
                            end
                        end else if (scl_fall) begin
                            if (bit_cnt == BITS_PER_BYTE) begin
                                serial_data_line_oe <= 1'b0;
                                state <= SSP_RD_ACK;
                            end else begin
                                shreg <= {shreg[6:0], 1'b0};
                                serial_data_line_oe <= ~shreg[6];
                            end
                        end
                    end
                    SSP_RD_ACK: begin
                        if (scl_rise) begin
                            ara_done <= is_ara;
                            state <= SSP_IDLE;
                        end
                    end
                    default: begin
                        state <= SSP_IDLE;
                    end
                endcase
            end
        end
    end

    // Pointer holds across operations and never advances
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ptr <= ZERO_RST;
        end else if (wr_ptr) begin
            ptr <= shreg;
        end
    end

    // Writable registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg <= CONFIG_RST;
            rate <= CONV_RATE_RST;
            lhi <= HIGH_LIMIT_RST;
            llo <= LOW_LIMIT_RST;
            rhi <= HIGH_LIMIT_RST;
            rlo <= LOW_LIMIT_RST;
            ofs_hi <= ZERO_RST;
            ofs_lo <= ZERO_RST;
            rhi_lo <= ZERO_RST;
            rlo_lo <= ZERO_RST;
            rfs_lim <= FS_LIMIT_RST;
            lfs_lim <= FS_LIMIT_RST;
            hyst <= HYSTERESIS_RST;
            consec <= CONSEC_RST;
        end else if (wr_reg) begin
            case (ptr)
                WR_CONFIG: cfg <= shreg;
                WR_CONV_RATE: rate <= shreg;
                WR_LOCAL_HIGH: lhi <= shreg;
                WR_LOCAL_LOW: llo <= shreg;
                WR_REMOTE_HIGH: rhi <= shreg;
                WR_REMOTE_LOW: rlo <= shreg;
                RW_OFFSET_HI: ofs_hi <= shreg;
                RW_OFFSET_LO: ofs_lo <= shreg;
                RW_REMOTE_HIGH_LO: rhi_lo <= shreg;
                RW_REMOTE_LOW_LO: rlo_lo <= shreg;
                RW_REMOTE_FS_LIMIT: rfs_lim <= shreg;
                RW_LOCAL_FS_LIMIT: lfs_lim <= shreg;
                RW_HYSTERESIS: hyst <= shreg;
                RW_CONSEC_ALARM: consec <= shreg;
                default: ;
            endcase
        end
    end

    assign standby = cfg[CFG_STANDBY_BIT];

    // Inactivity timeout; idle bus never counts
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            to_cnt <= 32'h0;
            to_hit <= 1'b0;
        end else begin
            to_hit <= 1'b0;
            if (state == SSP_IDLE || scl_rise || scl_fall
                || !(consec[CONSEC_TO_BIT_A] && consec[CONSEC_TO_BIT_B])) begin
                to_cnt <= 32'h0;
            end else if (to_cnt == 32'(TIMEOUT_CYC - 1)) begin
                to_cnt <= 32'h0;
                to_hit <= 1'b1;
            end else begin
                to_cnt <= to_cnt + 32'h1;
            end
        end
    end

    // Conversion sequencing
    assign abort_now = conv_busy && standby && !oneshot_run;
    assign take_result = conv_busy && meas_done && !abort_now;
    assign start_now = !conv_busy
        && ((!standby && conv_timer == 32'h0) || oneshot_pend);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            conv_busy <= 1'b0;
            conv_start <= 1'b0;
            conv_abort <= 1'b0;
            conv_timer <= 32'h0;
            oneshot_pend <= 1'b0;
            oneshot_run <= 1'b0;
        end else begin
            conv_start <= start_now;
            conv_abort <= abort_now;
            if (wr_reg && ptr == SINGLE_CONVERSION_TRIGGER && standby) begin
                oneshot_pend <= 1'b1;
            end else if (start_now) begin
                oneshot_pend <= 1'b0;
            end
            if (start_now) begin
                conv_busy <= 1'b1;
                oneshot_run <= oneshot_pend;
                conv_timer <= 32'(CONV_CYC - 1);
            end else if (abort_now || take_result) begin
                conv_busy <= 1'b0;
                oneshot_run <= 1'b0;
            end
            if (!start_now && conv_timer != 32'h0 && !standby) begin
                conv_timer <= conv_timer - 32'h1;
            end
        end
    end

    // Results are dropped when the conversion was aborted
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            local_t <= ZERO_RST;
            remote_hi <= ZERO_RST;
            remote_lo <= ZERO_RST;
        end else if (take_result) begin
            local_t <= meas_local;
            remote_hi <= meas_remote_hi;
            remote_lo <= meas_remote_lo;
        end
    end

    // Limits compared continuously, so new limits act even in standby
    assign c_lhi = above(local_t, lhi);
    assign c_llo = above(llo, local_t);
    assign c_rhi = above(remote_hi, rhi);
    assign c_rlo = above(rlo, remote_hi);
    assign c_rfs = above(remote_hi, rfs_lim);
    assign c_lfs = above(local_t, lfs_lim);

    // Status flags: a set in the cycle of a status read wins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flags <= 5'h00;
        end else begin
            if (fs_mode) begin
                flags[6:3] <= {c_lhi, c_llo, c_rhi, c_rlo};
            end else begin
                flags[6:3] <= (flags[6:3] & {4{~stat_clr}})
                    | {c_lhi, c_llo, c_rhi, c_rlo};
            end
            flags[2] <= (flags[2] & ~stat_clr)
                | (start_now & open_s);
        end
    end

    // Alarm latch, released by a completed alert response only if clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            alarm_active <= 1'b0;
        end else if (!fs_mode && !cfg[CFG_MASK_BIT] && |flags) begin
            alarm_active <= 1'b1;
        end else if (ara_done || fs_mode) begin
            alarm_active <= 1'b0;
        end
    end

    // Shared open-drain pin: alarm or second_failsafe_output
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            alarm_pin_oe <= 1'b0;
            alarm_pin_out <= 1'b0;
            serial_data_line_out <= 1'b0;
        end else begin
            alarm_pin_oe <= fs_mode ? (c_lhi | c_rhi) : alarm_active;
            alarm_pin_out <= 1'b0;
            serial_data_line_out <= 1'b0;
        end
    end

    logic unused_pin;
    assign unused_pin = alarm_pin_in;
endmodule : ssp_slave_port

// ### ssp_slave_port_assertions.sv
`timescale 1ns/1ps
module ssp_slave_port_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic serial_data_line_out,
    input wire logic serial_data_line_oe,
    input wire logic alarm_pin_out,
    input wire logic alarm_pin_oe,
    input wire logic meas_done,
    input wire logic conv_start,
    input wire logic conv_busy,
    input wire logic conv_abort
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    data_od_a: assert property (!serial_data_line_out)
        else $error("data out high");
    alarm_od_a: assert property (!alarm_pin_out)
        else $error("alarm out high");
    ack_low_a: assert property (
        $rose(serial_data_line_oe) |-> !scl_in) else $error("oe rose high");
    data_hold_a: assert property (
        scl_in [*2] |-> $stable(serial_data_line_oe)) else $error("oe moved");
    reset_quiet_a: assert property (disable iff (1'b0)
        !rst_n |=> !serial_data_line_oe && !alarm_pin_oe && !conv_busy)
        else $error("not quiet in reset");
    start_pulse_a: assert property (conv_start |=> !conv_start)
        else $error("start too long");
    start_busy_a: assert property (conv_start |-> conv_busy)
        else $error("start without busy");
    done_idle_a: assert property (meas_done && conv_busy |=> !conv_busy)
        else $error("busy after done");
    abort_idle_a: assert property (conv_abort |-> !conv_busy)
        else $error("busy after abort");
    cover property (conv_start);
    cover property ($rose(alarm_pin_oe));
    cover property ($rose(serial_data_line_oe));
endmodule : ssp_slave_port_chk
bind ssp_slave_port ssp_slave_port_chk u_chk (.clk(clk), .rst_n(rst_n),
    .scl_in(scl_in), .serial_data_line_out(serial_data_line_out),
    .serial_data_line_oe(serial_data_line_oe),
    .alarm_pin_out(alarm_pin_out), .alarm_pin_oe(alarm_pin_oe),
    .meas_done(meas_done), .conv_start(conv_start), .conv_busy(conv_busy),
    .conv_abort(conv_abort));

// ### ssp_smbus_master.sv
`timescale 1ns/1ps
module ssp_smbus_master (
    input wire logic clk,
    input wire logic sda,
    output logic scl = 1'b1,
    output logic sda_low = 1'b0
);
    task automatic q(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : q
    task automatic start_op();
        q(4);
        sda_low = 1'b1;
        q(4);
        scl = 1'b0;
    endtask : start_op
    // Long low phase leaves room for the slave's input synchroniser
    task automatic xbit(input logic b, output logic r);
        q(2);
        sda_low = !b;
        q(3);
        scl = 1'b1;
        q(3);
        r = sda;
        scl = 1'b0;
    endtask : xbit
    task automatic xfer(input logic [7:0] d, input logic a,
            output logic [7:0] r, output logic k);
        for (int i = 7; i >= 0; i--) xbit(d[i], r[i]);
        xbit(a, k);
    endtask : xfer
    task automatic stop_op();
        q(2);
        sda_low = 1'b1;
        q(3);
        scl = 1'b1;
        q(3);
        sda_low = 1'b0;
    endtask : stop_op
endmodule : ssp_smbus_master

// ### smbus_sensor_slave_port_tb_top.sv
`timescale 1ns/1ps
module smbus_sensor_slave_port_tb_top;
    import ssp_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic osen = 1'b0;
    logic [4:0] dly = 5'h00;
    int starts = 0;
    int failures = 0;
    int num_checks = 0;
    logic scl, m_low, sda, d_out, d_oe, a_out, a_oe, cs, ca, cb, sby;
    logic d2_oe;
    always #5 clk = ~clk;
    // Pull-up on the data line; the second device shares it
    assign sda = !(m_low || d_oe || d2_oe);
    always @(posedge clk) dly <= {dly[3:0], cs};
    always @(posedge clk) starts <= starts + int'(cs);
    ssp_slave_port #(.TIMEOUT_CYC(200), .CONV_CYC(100)) uut (.clk(clk),
        .rst_n(rst_n), .scl_in(scl), .serial_data_line_in(sda),
        .serial_data_line_out(d_out), .serial_data_line_oe(d_oe),
        .alarm_pin_in(!a_oe), .alarm_pin_out(a_out), .alarm_pin_oe(a_oe),
        .open_sensor_in(osen), .meas_done(dly[4]), .meas_local(8'h19),
        .meas_remote_hi(8'h19), .meas_remote_lo(8'h00), .conv_start(cs),
        .conv_abort(ca), .conv_busy(cb), .standby(sby));
    // Alternate-address device; measurements never finish, open-sensor input tied low, but flag bit 2 latches at the first start as the synchroniser resets high
    ssp_slave_port #(.ALT_VARIANT(1'b1), .TIMEOUT_CYC(200), .CONV_CYC(100))
        uut_alt (.clk(clk), .rst_n(rst_n), .scl_in(scl),
        .serial_data_line_in(sda), .serial_data_line_out(),
        .serial_data_line_oe(d2_oe), .alarm_pin_in(1'b1),
        .alarm_pin_out(), .alarm_pin_oe(), .open_sensor_in(1'b0),
        .meas_done(1'b0), .meas_local(8'h00), .meas_remote_hi(8'h00),
        .meas_remote_lo(8'h00), .conv_start(), .conv_abort(),
        .conv_busy(), .standby());
    ssp_smbus_master m (.clk(clk), .sda(sda), .scl(scl), .sda_low(m_low));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [6:0] a, input int n, input logic [7:0] p,
            input logic [7:0] d);
        logic [7:0] r;
        logic k;
        m.start_op();
        m.xfer({a, 1'b0}, 1'b1, r, k);
        chk({7'h0, k}, {7'h0, n == 0});
        if (n > 0) m.xfer(p, 1'b1, r, k);
        if (n > 0) chk({7'h0, k}, 8'h00);
        if (n > 1) m.xfer(d, 1'b1, r, k);
        if (n > 1) chk({7'h0, k}, 8'h00);
        m.stop_op();
    endtask : wr
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] r;
        logic k;
        m.start_op();
        m.xfer({a, 1'b1}, 1'b1, r, k);
        chk({7'h0, k}, 8'h00);
        m.xfer(8'hFF, 1'b1, r, k);
        chk(r, e);
        m.stop_op();
    endtask : rd
    task automatic t_pointer();
        chk({7'h0, d_oe}, 8'h00);
        wr(7'h4E, 0, 8'h00, 8'h00);
        wr(DEV_ADDR_ALT, 1, RD_CONFIG, 8'h00);
        wr(DEV_ADDR_STD, 2, WR_CONFIG, 8'h48);
        chk({7'h0, sby}, 8'h01);
        wr(DEV_ADDR_STD, 1, RD_CONFIG, 8'h00);
        rd(DEV_ADDR_STD, 8'h48);
        rd(DEV_ADDR_STD, 8'h48);
    endtask : t_pointer
    task automatic t_one_shot();
        int s0;
        s0 = starts;
        osen = 1'b1;
        wr(DEV_ADDR_STD, 2, SINGLE_CONVERSION_TRIGGER, 8'hA5);
        for (int i = 0; i < 50 && starts == s0; i++) @(posedge clk);
        repeat (10) @(posedge clk);
        #1;
        chk(8'(starts - s0), 8'h01);
        chk({7'h0, sby}, 8'h01);
        chk({7'h0, a_oe}, 8'h01);
        rd(DEV_ADDR_STD, 8'h00);
    endtask : t_one_shot
    task automatic t_alert();
        osen = 1'b0;
        rd(ALERT_RESP_ADDR, {DEV_ADDR_STD, 1'b1});
        chk({7'h0, a_oe}, 8'h01);
        wr(DEV_ADDR_STD, 1, RD_STATUS, 8'h00);
        rd(DEV_ADDR_STD, 8'h04);
        rd(ALERT_RESP_ADDR, {DEV_ADDR_STD, 1'b1});
        chk({7'h0, a_oe}, 8'h00);
        rd(DEV_ADDR_STD, 8'h00);
    endtask : t_alert
    task automatic end_of_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (12) @(posedge clk);
        #1;
        rst_n = 1'b1;
        repeat (8) @(posedge clk);
        #1;
        t_pointer();
        t_one_shot();
        t_alert();
        end_of_test();
    end
    initial begin
        #500000;
        failures++;
        end_of_test();
    end
endmodule : smbus_sensor_slave_port_tb_top
